// *** src/fault_supervisor.sv ***
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
module fault_supervisor #(
   parameter logic [15:0] BCR_TIMEOUT_CYCLES = 16'(fault_supervisor_pkg::BCR_TIMEOUT_CYC)
) (
   // Clock and reset.
   input wire logic core_clk_i,
   input wire logic reset_i,
   // APB slave.
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Asynchronous monitor pins.
   input wire logic low_freq_clock_i,
   input wire logic main_clock_toggle_i,
   input wire logic fcc_source_clk_i,
   input wire logic fcc_ref_clk_i,
   input wire logic vdd_below_warn_i,
   input wire logic vdd_below_reset_i,
   // System controller status.
   input wire logic [1:0] power_mode_i,
   input wire logic wakeup_event_i,
   input wire logic boot_routine_active_i,
   input wire logic boot_cfg_integrity_err_i,
   input wire logic trim_integrity_err_i,
   // Reset, interrupt and supervisor outputs.
   output logic boot_reset_o,
   output logic por_request_o,
   output logic nmi_o,
   output logic brownout_violation_o,
   output logic brownout_reset_o,
   output logic irq_o
);
   logic [5:0] lvl;
   logic [5:0] prev_r;
   logic [3:0] ctrl_r, ctrl_nxt;
   logic [4:0] status_r, status_nxt;
   logic [4:0] int_en_r, int_en_nxt;
   logic [1:0] cause_r, cause_nxt;
   logic [7:0] fcc_cfg_r, fcc_cfg_nxt;
   logic [31:0] ret_r [fault_supervisor_pkg::RET_WORDS];
   logic [31:0] ret_nxt [fault_supervisor_pkg::RET_WORDS];
   logic par_r [fault_supervisor_pkg::RET_WORDS];
   logic par_nxt [fault_supervisor_pkg::RET_WORDS];
   fault_supervisor_pkg::ret_state_t ret_state_r, ret_state_nxt;
   logic [3:0] lf_cnt_r, lf_cnt_nxt;
   logic [15:0] bcr_cnt_r, bcr_cnt_nxt;
   logic boot_reset_r, boot_reset_nxt;
   logic por_req_r, por_req_nxt;
   logic nmi_r, nmi_nxt;
   logic bor_armed_r, bor_armed_nxt;
   logic bor_viol_r, bor_rst_r;
   logic irq_r, irq_nxt;
   logic fcc_start_r, fcc_start_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic pready_r, pready_nxt;
   logic pslverr_r, pslverr_nxt;
   logic lf_rise, mclk_act, monitor_on, mclk_fault;
   logic bcr_timeout, boot_fail, par_err, in_shutdown, bor_trip;
   logic access, wr_go, ret_idx;
   logic [4:0] set_mask, clr_mask;

   fcc_link_if fcc_bus ();

   pin_sync3 #(.W(fault_supervisor_pkg::SYNC_W)) u_sync (
      .core_clk_i(core_clk_i),
      .reset_i(reset_i),
      .pin_i({vdd_below_reset_i, vdd_below_warn_i, fcc_ref_clk_i, fcc_source_clk_i,
              main_clock_toggle_i, low_freq_clock_i}),
      .level_o(lvl)
   );

   freq_clock_counter u_fcc (
      .core_clk_i(core_clk_i),
      .reset_i(reset_i),
      .f(fcc_bus.cnt)
   );

   assign fcc_bus.start = fcc_start_r;
   assign fcc_bus.periods = fcc_cfg_r;
   assign fcc_bus.src_rise = lvl[2] & ~prev_r[2];
   assign fcc_bus.ref_rise = lvl[3] & ~prev_r[3];

   always_comb begin
      lf_rise = lvl[0] & ~prev_r[0];
      mclk_act = lvl[1] ^ prev_r[1];
      in_shutdown = (power_mode_i == fault_supervisor_pkg::MODE_SHUTDOWN);
      monitor_on = ctrl_r[fault_supervisor_pkg::CTRL_MCLK_CHK] && !in_shutdown &&
                   (power_mode_i != fault_supervisor_pkg::MODE_DEEP_STANDBY);
      // Slow-clock edges without main clock activity.
      mclk_fault = monitor_on && lf_rise && !mclk_act &&
                   (lf_cnt_r == fault_supervisor_pkg::MCLK_DEAD_LF_CYCLES - 4'h1);
      if (!monitor_on || mclk_act || mclk_fault) begin
         lf_cnt_nxt = 4'h0;
      end else if (lf_rise) begin
         lf_cnt_nxt = lf_cnt_r + 4'h1;
      end else begin
         lf_cnt_nxt = lf_cnt_r;
      end
      bcr_timeout = boot_routine_active_i && (bcr_cnt_r == BCR_TIMEOUT_CYCLES - 16'h0001);
      bcr_cnt_nxt = (!boot_routine_active_i || bcr_timeout) ? 16'h0000 : bcr_cnt_r + 16'h0001;
      boot_fail = boot_routine_active_i && (boot_cfg_integrity_err_i || trim_integrity_err_i || bcr_timeout);
      boot_reset_nxt = mclk_fault || boot_fail;
      // Warning trip raises NMI once and arms the supervisor.
      bor_trip = ctrl_r[fault_supervisor_pkg::CTRL_BOR_MON] && !bor_armed_r && lvl[4];
      nmi_nxt = bor_trip;
      bor_armed_nxt = ctrl_r[fault_supervisor_pkg::CTRL_BOR_MON] && (bor_armed_r || bor_trip);
      par_err = 1'b0;
      for (int i = 0; i < fault_supervisor_pkg::RET_WORDS; i++) begin
         par_err = par_err | (^ret_r[i] ^ par_r[i]);
      end
   end

   always_comb begin
      ctrl_nxt = ctrl_r;
      int_en_nxt = int_en_r;
      fcc_cfg_nxt = fcc_cfg_r;
      cause_nxt = cause_r;
      ret_state_nxt = ret_state_r;
      por_req_nxt = 1'b0;
      clr_mask = 5'h00;
      ret_nxt = ret_r;
      par_nxt = par_r;
      access = psel_i && penable_i;
      wr_go = access && pready_r && pwrite_i;
      ret_idx = (paddr_i == fault_supervisor_pkg::ADDR_RET1);
      fcc_start_nxt = 1'b0;
      if (wr_go) begin
         unique case (paddr_i)
            fault_supervisor_pkg::ADDR_CTRL: begin
               ctrl_nxt = pwdata_i[3:0] & fault_supervisor_pkg::CTRL_STORED_MASK;
               fcc_start_nxt = pwdata_i[fault_supervisor_pkg::CTRL_FCC_START];
            end
            fault_supervisor_pkg::ADDR_INT_EN: int_en_nxt = pwdata_i[4:0];
            fault_supervisor_pkg::ADDR_INT_CLR: clr_mask = pwdata_i[4:0];
            fault_supervisor_pkg::ADDR_FCC_CFG: fcc_cfg_nxt = pwdata_i[7:0];
            fault_supervisor_pkg::ADDR_RET0, fault_supervisor_pkg::ADDR_RET1: begin
               ret_nxt[ret_idx] = pwdata_i;
               par_nxt[ret_idx] = ^pwdata_i ^ ctrl_r[fault_supervisor_pkg::CTRL_PAR_INJECT];
            end
            default: ;
         endcase
      end
      if (boot_reset_nxt) begin
         cause_nxt = fault_supervisor_pkg::CAUSE_BOOT;
      end
      unique case (ret_state_r)
         fault_supervisor_pkg::RET_OK: begin
            // Defer the reset while in shutdown.
            if (par_err) begin
               ret_state_nxt = in_shutdown ? fault_supervisor_pkg::RET_HOLD : fault_supervisor_pkg::RET_CLEAR;
            end else if (in_shutdown && wakeup_event_i) begin
               cause_nxt = fault_supervisor_pkg::CAUSE_SHDN_WAKE;
            end
         end
         fault_supervisor_pkg::RET_HOLD: begin
            if (wakeup_event_i) begin
               ret_state_nxt = fault_supervisor_pkg::RET_CLEAR;
            end
         end
         fault_supervisor_pkg::RET_CLEAR: begin
            // Request reset and clear the store.
            por_req_nxt = 1'b1;
            cause_nxt = fault_supervisor_pkg::CAUSE_POR;
            for (int i = 0; i < fault_supervisor_pkg::RET_WORDS; i++) begin
               ret_nxt[i] = 32'h00000000;
               par_nxt[i] = 1'b0;
            end
            ret_state_nxt = fault_supervisor_pkg::RET_OK;
         end
         default: ret_state_nxt = fault_supervisor_pkg::RET_OK;
      endcase
      set_mask = {fcc_bus.done, bor_trip, par_err && (ret_state_r == fault_supervisor_pkg::RET_OK),
                  boot_fail, mclk_fault};
      // A new event wins over a clear in the same cycle.
      status_nxt = (status_r & ~clr_mask) | set_mask;
      irq_nxt = |(status_nxt & int_en_nxt);
      pready_nxt = access && !pready_r;
      pslverr_nxt = 1'b0;
      prdata_nxt = 32'h00000000;
      if (access && !pready_r) begin
         unique case (paddr_i)
            fault_supervisor_pkg::ADDR_CTRL: prdata_nxt = {28'h0000000, ctrl_r};
            fault_supervisor_pkg::ADDR_STATUS: prdata_nxt = {27'h0000000, status_r};
            fault_supervisor_pkg::ADDR_INT_EN: prdata_nxt = {27'h0000000, int_en_r};
            fault_supervisor_pkg::ADDR_INT_CLR: prdata_nxt = 32'h00000000;
            fault_supervisor_pkg::ADDR_CAUSE: prdata_nxt = {30'h00000000, cause_r};
            fault_supervisor_pkg::ADDR_FCC_CFG: prdata_nxt = {24'h000000, fcc_cfg_r};
            fault_supervisor_pkg::ADDR_FCC_COUNT: prdata_nxt = fcc_bus.count;
            fault_supervisor_pkg::ADDR_RET0, fault_supervisor_pkg::ADDR_RET1: prdata_nxt = ret_r[ret_idx];
            default: pslverr_nxt = 1'b1;
         endcase
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         prev_r <= 6'h00;
         ctrl_r <= fault_supervisor_pkg::CTRL_RESET;
         status_r <= fault_supervisor_pkg::STATUS_RESET;
         int_en_r <= 5'h00;
         cause_r <= fault_supervisor_pkg::CAUSE_NONE;
         fcc_cfg_r <= fault_supervisor_pkg::FCC_CFG_RESET;
         for (int i = 0; i < fault_supervisor_pkg::RET_WORDS; i++) begin
            ret_r[i] <= 32'h00000000;
            par_r[i] <= 1'b0;
         end
         ret_state_r <= fault_supervisor_pkg::RET_OK;
         lf_cnt_r <= 4'h0;
         bcr_cnt_r <= 16'h0000;
         boot_reset_r <= 1'b0;
         por_req_r <= 1'b0;
         nmi_r <= 1'b0;
         bor_armed_r <= 1'b0;
         bor_viol_r <= 1'b0;
         bor_rst_r <= 1'b0;
         irq_r <= 1'b0;
         fcc_start_r <= 1'b0;
         prdata_r <= 32'h00000000;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         prev_r <= lvl;
         ctrl_r <= ctrl_nxt;
         status_r <= status_nxt;
         int_en_r <= int_en_nxt;
         cause_r <= cause_nxt;
         fcc_cfg_r <= fcc_cfg_nxt;
         ret_r <= ret_nxt;
         par_r <= par_nxt;
         ret_state_r <= ret_state_nxt;
         lf_cnt_r <= lf_cnt_nxt;
         bcr_cnt_r <= bcr_cnt_nxt;
         boot_reset_r <= boot_reset_nxt;
         por_req_r <= por_req_nxt;
         nmi_r <= nmi_nxt;
         bor_armed_r <= bor_armed_nxt;
         bor_viol_r <= lvl[5];
         bor_rst_r <= bor_armed_nxt && lvl[5];
         irq_r <= irq_nxt;
         fcc_start_r <= fcc_start_nxt;
         prdata_r <= prdata_nxt;
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   assign prdata_o = prdata_r;
   assign pready_o = pready_r;
   assign pslverr_o = pslverr_r;
   assign boot_reset_o = boot_reset_r;
   assign por_request_o = por_req_r;
   assign nmi_o = nmi_r;
   assign brownout_violation_o = bor_viol_r;
   assign brownout_reset_o = bor_rst_r;
   assign irq_o = irq_r;

   a_mclk_dead_window: assert property (@(posedge core_clk_i) disable iff (reset_i)
      (monitor_on && lf_rise && !mclk_act && lf_cnt_r == 4'hB)
      |=> (boot_reset_r && status_r[fault_supervisor_pkg::ST_MCLK_FAULT] && lf_cnt_r == 4'h0))
      else $error("Main clock fault not raised at window end.");

   a_mclk_boot_reset: assert property (@(posedge core_clk_i) disable iff (reset_i)
      mclk_fault |=> (boot_reset_r && cause_r == fault_supervisor_pkg::CAUSE_BOOT))
      else $error("Main clock fault did not cause boot reset.");

   a_mclk_enable_gate: assert property (@(posedge core_clk_i) disable iff (reset_i)
      !ctrl_r[fault_supervisor_pkg::CTRL_MCLK_CHK] |=> (lf_cnt_r == 4'h0))
      else $error("Main clock monitor counted while disabled.");

   a_mclk_mode_gate: assert property (@(posedge core_clk_i) disable iff (reset_i)
      (power_mode_i == fault_supervisor_pkg::MODE_DEEP_STANDBY || in_shutdown) |=> !boot_reset_r || $past(boot_fail))
      else $error("Main clock monitor acted in a suspended mode.");

   a_boot_retry: assert property (@(posedge core_clk_i) disable iff (reset_i)
      (boot_routine_active_i && (boot_cfg_integrity_err_i || trim_integrity_err_i))
      |=> (boot_reset_r && status_r[fault_supervisor_pkg::ST_BOOT_FAIL]))
      else $error("Boot failure did not cause boot reset.");

   a_par_por_req: assert property (@(posedge core_clk_i) disable iff (reset_i)
      (ret_state_r == fault_supervisor_pkg::RET_OK && par_err && !in_shutdown)
      |=> !por_req_r ##1 (por_req_r && cause_r == fault_supervisor_pkg::CAUSE_POR && !par_err))
      else $error("Parity error did not request power-on reset.");

   a_par_deferred: assert property (@(posedge core_clk_i) disable iff (reset_i)
      (ret_state_r == fault_supervisor_pkg::RET_HOLD && !wakeup_event_i) |=> !por_req_r ##1 !por_req_r)
      else $error("Parity reset issued during shutdown.");

   a_par_cause: assert property (@(posedge core_clk_i) disable iff (reset_i)
      por_req_r |-> (cause_r == fault_supervisor_pkg::CAUSE_POR && ret_r[0] == 32'h00000000))
      else $error("Parity reset reported wrong cause.");

   a_bor_nmi_arm: assert property (@(posedge core_clk_i) disable iff (reset_i)
      bor_trip |=> (nmi_r && bor_armed_r) ##1 !nmi_r)
      else $error("Brownout warning did not raise NMI and arm.");

   a_bor_violation: assert property (@(posedge core_clk_i) disable iff (reset_i)
      brownout_reset_o |-> brownout_violation_o)
      else $error("Supervisor reset without violation.");
endmodule : fault_supervisor

// *** src/fault_supervisor_pkg.sv ***
// Summary of operation
// - Main clock silent 11-12 slow cycles: fault.
// - Every main clock fault causes boot reset.
// - Monitor runs only when dead-check enable set.
// - Monitor suspended in deep standby and shutdown.
// - Failed boot routine triggers boot reset retry.
// - Boot fails on config, trim or timeout.
// - Retention parity error requests power-on reset.
// - In shutdown, reset waits for next wakeup.
// - Parity reset reports power-on, not shutdown wakeup.
// - Brownout warning raises NMI, arms supervisor reset.
// - Violation output follows supply out-of-range condition.
// - Counter counts source clocks over reference window.
package fault_supervisor_pkg;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_INT_EN = 8'h08;
   localparam logic [7:0] ADDR_INT_CLR = 8'h0C;
   localparam logic [7:0] ADDR_CAUSE = 8'h10;
   localparam logic [7:0] ADDR_FCC_CFG = 8'h14;
   localparam logic [7:0] ADDR_FCC_COUNT = 8'h18;
   localparam logic [7:0] ADDR_RET0 = 8'h1C;
   localparam logic [7:0] ADDR_RET1 = 8'h20;

   localparam int CTRL_MCLK_CHK = 0;
   localparam int CTRL_BOR_MON = 1;
   localparam int CTRL_FCC_START = 2;
   localparam int CTRL_PAR_INJECT = 3;
   localparam int CTRL_W = 4;
   localparam logic [3:0] CTRL_RESET = 4'h0;
   localparam logic [3:0] CTRL_STORED_MASK = 4'hB;

   localparam int ST_MCLK_FAULT = 0;
   localparam int ST_BOOT_FAIL = 1;
   localparam int ST_PARITY = 2;
   localparam int ST_BOR_WARN = 3;
   localparam int ST_FCC_DONE = 4;
   localparam int STATUS_W = 5;
   localparam logic [4:0] STATUS_RESET = 5'h00;

   localparam logic [1:0] CAUSE_NONE = 2'h0;
   localparam logic [1:0] CAUSE_POR = 2'h1;
   localparam logic [1:0] CAUSE_SHDN_WAKE = 2'h2;
   localparam logic [1:0] CAUSE_BOOT = 2'h3;

   localparam logic [1:0] MODE_RUN = 2'h0;
   localparam logic [1:0] MODE_SLEEP = 2'h1;
   localparam logic [1:0] MODE_DEEP_STANDBY = 2'h2;
   localparam logic [1:0] MODE_SHUTDOWN = 2'h3;

   localparam logic [3:0] MCLK_DEAD_LF_CYCLES = 4'hC;
   localparam logic [7:0] FCC_CFG_RESET = 8'h01;
   localparam int RET_WORDS = 2;
   localparam int SYNC_W = 6;

   localparam int CLK_PERIOD_NS = 100;
   localparam int BCR_TIMEOUT_NS = 1000000;
   localparam int BCR_TIMEOUT_CYC = BCR_TIMEOUT_NS / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      RET_OK = 2'b00,
      RET_HOLD = 2'b01,
      RET_CLEAR = 2'b11
   } ret_state_t;

   typedef enum logic [1:0] {
      FCC_IDLE = 2'b00,
      FCC_ARM = 2'b01,
      FCC_COUNT = 2'b11,
      FCC_DONE = 2'b10
   } fcc_state_t;
endpackage : fault_supervisor_pkg

// *** src/fcc_link_if.sv ***
`timescale 1ns/1ns
interface fcc_link_if;
   logic start;
   logic [7:0] periods;
   logic src_rise;
   logic ref_rise;
   logic [31:0] count;
   logic done;
   logic busy;
   modport ctl (output start, periods, src_rise, ref_rise, input count, done, busy);
   modport cnt (input start, periods, src_rise, ref_rise, output count, done, busy);
endinterface : fcc_link_if

// *** src/pin_sync3.sv ***
`timescale 1ns/1ns
module pin_sync3 #(
   parameter int W = 1
) (
   // Clock and reset.
   input wire logic core_clk_i,
   input wire logic reset_i,
   // Raw pins and filtered levels.
   input wire logic [W-1:0] pin_i,
   output logic [W-1:0] level_o
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;
   logic [W-1:0] level_r;
   logic [W-1:0] level_nxt;

   // A bit changes only once the second and third stages agree.
   always_comb begin
      level_nxt = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & level_r);
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         level_r <= '0;
      end else begin
         s1_r <= pin_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
         level_r <= level_nxt;
      end
   end

   assign level_o = level_r;
endmodule : pin_sync3

// *** src/freq_clock_counter.sv ***
`timescale 1ns/1ns
module freq_clock_counter (
   // Clock and reset.
   input wire logic core_clk_i,
   input wire logic reset_i,
   // Control and result.
   fcc_link_if.cnt f
);
   fault_supervisor_pkg::fcc_state_t state_r;
   fault_supervisor_pkg::fcc_state_t state_nxt;
   logic [31:0] count_r;
   logic [31:0] count_nxt;
   logic [7:0] left_r;
   logic [7:0] left_nxt;
   logic done_r;
   logic done_nxt;

   always_comb begin
      state_nxt = state_r;
      count_nxt = count_r;
      left_nxt = left_r;
      done_nxt = 1'b0;
      unique case (state_r)
         fault_supervisor_pkg::FCC_IDLE, fault_supervisor_pkg::FCC_DONE: begin
            if (f.start) begin
               state_nxt = fault_supervisor_pkg::FCC_ARM;
               count_nxt = '0;
               left_nxt = (f.periods == 8'h00) ? 8'h01 : f.periods;
            end
         end
         fault_supervisor_pkg::FCC_ARM: begin
            if (f.ref_rise) begin
               state_nxt = fault_supervisor_pkg::FCC_COUNT;
            end
         end
         fault_supervisor_pkg::FCC_COUNT: begin
            if (f.src_rise) begin
               count_nxt = count_r + 32'h00000001;
            end
            if (f.ref_rise) begin
               left_nxt = left_r - 8'h01;
               if (left_r == 8'h01) begin
                  state_nxt = fault_supervisor_pkg::FCC_DONE;
                  done_nxt = 1'b1;
               end
            end
         end
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         state_r <= fault_supervisor_pkg::FCC_IDLE;
         count_r <= '0;
         left_r <= 8'h00;
         done_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         count_r <= count_nxt;
         left_r <= left_nxt;
         done_r <= done_nxt;
      end
   end

   assign f.count = count_r;
   assign f.done = done_r;
   assign f.busy = (state_r == fault_supervisor_pkg::FCC_ARM) || (state_r == fault_supervisor_pkg::FCC_COUNT);

   a_fcc_count_held: assert property (@(posedge core_clk_i) disable iff (reset_i)
      (state_r == fault_supervisor_pkg::FCC_DONE && !f.start) |=> $stable(count_r))
      else $error("Frequency count changed after completion.");

   a_fcc_window_end: assert property (@(posedge core_clk_i) disable iff (reset_i)
      (state_r == fault_supervisor_pkg::FCC_COUNT && f.ref_rise && left_r == 8'h01)
      |=> (done_r && state_r == fault_supervisor_pkg::FCC_DONE) ##1 !done_r)
      else $error("Frequency count did not finish at window end.");
endmodule : freq_clock_counter

// *** verification/clock_env_model.sv ***
`timescale 1ns/1ns
module clock_env_model (
   // Clock and control.
   input wire logic core_clk_i,
   input wire logic main_run_i,
   // Clock sources.
   output logic low_freq_clock_o,
   output logic main_toggle_o,
   output logic src_clk_o,
   output logic ref_clk_o
);
   logic [4:0] div_r;
   initial begin
      div_r = 5'h00;
      {low_freq_clock_o, main_toggle_o, src_clk_o, ref_clk_o} = 4'h0;
   end
   // Each level is held at least four core cycles so the synchronisers see it.
   always @(posedge core_clk_i) begin
      div_r <= div_r + 5'h01;
      low_freq_clock_o <= div_r[3];
      src_clk_o <= div_r[2];
      ref_clk_o <= div_r[4];
      if (main_run_i) begin
         main_toggle_o <= div_r[2];
      end
   end
endmodule : clock_env_model

// *** verification/fault_supervisor_tb.sv ***
`timescale 1ns/1ns
module fault_supervisor_tb;
   logic core_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, main_run = 1;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata_o, r;
   logic pready_o, pslverr_o, perr, lf, mt, sc, rc, warn = 0, vlow = 0, wake = 0, act = 0, cfg_e = 0, trim_e = 0;
   logic [1:0] mode = 2'h0;
   logic boot_reset_o, por_request_o, nmi_o, viol_o, bor_o, irq_o;
   wire [2:0] outs = {nmi_o, por_request_o, boot_reset_o};
   int n_errors = 0, num_checks = 0, cyc = 0;
   always #50 core_clk = ~core_clk;
   clock_env_model i_clock_env_model (.core_clk_i(core_clk), .main_run_i(main_run), .low_freq_clock_o(lf),
      .main_toggle_o(mt), .src_clk_o(sc), .ref_clk_o(rc));
   fault_supervisor #(.BCR_TIMEOUT_CYCLES(16'h0014)) i_fault_supervisor (.core_clk_i(core_clk), .reset_i(reset),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .low_freq_clock_i(lf),
      .main_clock_toggle_i(mt), .fcc_source_clk_i(sc), .fcc_ref_clk_i(rc), .vdd_below_warn_i(warn),
      .vdd_below_reset_i(vlow), .power_mode_i(mode), .wakeup_event_i(wake), .boot_routine_active_i(act),
      .boot_cfg_integrity_err_i(cfg_e), .trim_integrity_err_i(trim_e), .boot_reset_o(boot_reset_o),
      .por_request_o(por_request_o), .nmi_o(nmi_o), .brownout_violation_o(viol_o),
      .brownout_reset_o(bor_o), .irq_o(irq_o));
   task automatic test_done();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : test_done
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         test_done();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %0t %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : check
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready_o !== 1'b1);
      r = prdata_o;
      perr = pslverr_o;
      {psel, penable} <= 2'b00;
   endtask : apb
   task automatic wait_pulse(input int b, input int lim, input logic exp, input string msg);
      logic hit;
      hit = 0;
      repeat (lim) begin
         @(posedge core_clk);
         if (outs[b] === 1'b1) hit = 1;
         if (hit && exp) break;
      end
      check({31'h0, hit}, {31'h0, exp}, msg);
   endtask : wait_pulse
   task automatic regs_at_reset();
      apb(0, fault_supervisor_pkg::ADDR_FCC_CFG, 0); check(r, 32'h1, "fcc cfg reset");
      apb(1, fault_supervisor_pkg::ADDR_STATUS, 32'h1F); apb(0, fault_supervisor_pkg::ADDR_STATUS, 0);
      check(r, 32'h0, "status read only");
      apb(0, 8'h40, 0); check({31'h0, perr}, 32'h1, "unmapped error");
   endtask : regs_at_reset
   task automatic main_dead();
      apb(1, fault_supervisor_pkg::ADDR_INT_EN, 32'h1); apb(1, fault_supervisor_pkg::ADDR_CTRL, 32'h1);
      main_run <= 0;
      for (int m = 2; m < 4; m++) begin
         mode <= 2'(m);
         wait_pulse(0, 400, 0, "suspended in low power");
      end
      mode <= fault_supervisor_pkg::MODE_SLEEP;
      wait_pulse(0, 400, 1, "dead clock boot reset");
      main_run <= 1;
      apb(0, fault_supervisor_pkg::ADDR_CAUSE, 0); check(r, 32'h3, "boot cause");
      check({31'h0, irq_o}, 32'h1, "irq raised");
      apb(1, fault_supervisor_pkg::ADDR_INT_CLR, 32'h1); repeat (2) @(posedge core_clk);
      check({31'h0, irq_o}, 32'h0, "irq cleared");
      apb(1, fault_supervisor_pkg::ADDR_CTRL, 32'h0); main_run <= 0;
      wait_pulse(0, 400, 0, "monitor disabled");
      main_run <= 1; mode <= fault_supervisor_pkg::MODE_RUN;
   endtask : main_dead
   task automatic boot_fail(input int k);
      act <= 1; cfg_e <= (k == 0); trim_e <= (k == 1);
      wait_pulse(0, 40, 1, "boot retry");
      {act, cfg_e, trim_e} <= 3'b000;
      apb(0, fault_supervisor_pkg::ADDR_STATUS, 0); check(r & 32'h2, 32'h2, "boot fail status");
      apb(1, fault_supervisor_pkg::ADDR_INT_CLR, 32'h2);
   endtask : boot_fail
   task automatic parity(input logic shut);
      mode <= shut ? fault_supervisor_pkg::MODE_SHUTDOWN : fault_supervisor_pkg::MODE_RUN;
      apb(1, fault_supervisor_pkg::ADDR_CTRL, 32'h8);
      if (shut) begin
         wake <= 1; @(posedge core_clk); wake <= 0;
         apb(0, fault_supervisor_pkg::ADDR_CAUSE, 0); check(r, 32'h2, "shutdown wake cause");
      end
      apb(1, fault_supervisor_pkg::ADDR_RET0, 32'h5);
      if (shut) begin
         wait_pulse(1, 40, 0, "por held in shutdown");
         wake <= 1; @(posedge core_clk); wake <= 0;
      end
      wait_pulse(1, 20, 1, "parity por");
      apb(1, fault_supervisor_pkg::ADDR_CTRL, 32'h0); mode <= fault_supervisor_pkg::MODE_RUN;
      apb(0, fault_supervisor_pkg::ADDR_CAUSE, 0); check(r, 32'h1, "cause power on");
      apb(0, fault_supervisor_pkg::ADDR_RET0, 0); check(r, 32'h0, "retention cleared");
   endtask : parity
   task automatic brownout();
      apb(1, fault_supervisor_pkg::ADDR_CTRL, 32'h2); warn <= 1;
      wait_pulse(2, 20, 1, "brownout nmi");
      vlow <= 1; repeat (8) @(posedge core_clk);
      check({30'h0, viol_o, bor_o}, 32'h3, "supervisor armed");
      {vlow, warn} <= 2'b00; repeat (8) @(posedge core_clk);
      check({31'h0, viol_o}, 32'h0, "violation cleared");
   endtask : brownout
   task automatic freq_count();
      logic [31:0] c;
      apb(1, fault_supervisor_pkg::ADDR_FCC_CFG, 32'h2); apb(1, fault_supervisor_pkg::ADDR_CTRL, 32'h4);
      repeat (60) begin
         apb(0, fault_supervisor_pkg::ADDR_STATUS, 0);
         if (r[4] === 1'b1) break;
      end
      check(r & 32'h10, 32'h10, "count done");
      apb(0, fault_supervisor_pkg::ADDR_FCC_COUNT, 0); c = r;
      check({31'h0, c >= 7 && c <= 9}, 32'h1, "eight source periods");
      repeat (40) @(posedge core_clk);
      apb(0, fault_supervisor_pkg::ADDR_FCC_COUNT, 0); check(r, c, "count held");
   endtask : freq_count
   initial begin
      repeat (12) @(posedge core_clk);
      reset <= 0;
      regs_at_reset();
      main_dead();
      for (int k = 0; k < 3; k++) boot_fail(k);
      parity(0);
      parity(1);
      brownout();
      freq_count();
      test_done();
   end
endmodule : fault_supervisor_tb
